// >>> logic/fsc_pkg.sv
// shared constants and types for the fan speed controller block
package fsc_pkg;

	// ==========================================
	// clock and timing
	localparam logic [63:0] CLK_HZ         = 64'h5F5E100;                  // system clock rate, 100 MHz
	localparam logic [63:0] SETTLE_TIME_S  = 64'h1E;                       // settling time after speed change, s
	localparam logic [31:0] SETTLE_CYCLES  = 32'(SETTLE_TIME_S * CLK_HZ);  // settling time in clock cycles
	localparam logic [63:0] POLL_TIME_US   = 64'h3E8;                      // gap between status polls, us
	localparam logic [31:0] POLL_CYCLES    = 32'(POLL_TIME_US * CLK_HZ / 64'hF4240); // poll gap in cycles

	// ==========================================
	// fan controller chip map
	localparam logic [6:0]  DEV_ADDR       = 7'h1B;  // seven-bit bus address of the chip
	localparam logic [7:0]  REG_SPEED      = 8'h00;  // target speed register
	localparam logic [7:0]  REG_CONFIG     = 8'h02;  // configuration register
	localparam logic [7:0]  REG_ALARM_EN   = 8'h08;  // alarm enable register
	localparam logic [7:0]  REG_ALARM_STAT = 8'h0A;  // alarm status register
	localparam logic [7:0]  REG_SPEED_COUNTER_OVERFLOW_ALARM       = 8'h0C;  // tachometer count register
	localparam logic [7:0]  CONFIG_VAL     = 8'h2A;  // closed-loop regulation, 12 V fan, prescale 4
	localparam logic [7:0]  ALARM_EN_VAL   = 8'h0F;  // enable alarm bits 0 to 3
	localparam logic [7:0]  SPEED_2000     = 8'h3A;  // speed word for about 2000 rpm
	localparam logic [7:0]  SPEED_5000     = 8'h16;  // speed word for about 5000 rpm

	// ==========================================
	// alarm status field positions
	localparam int          ALM_MAX_POS    = 0;  // output at maximum level
	localparam int          ALM_MIN_POS    = 1;  // output at minimum level
	localparam int          ALM_OVF_POS    = 2;  // speed_counter_overflow_alarm
	localparam int          ALM_GIN1_POS   = 3;  // general_input_one_alarm
	localparam logic [3:0]  LED_RESET      = 4'h0;  // alarm leds after reset

	// ==========================================
	// state types
	typedef enum logic [2:0] {
		B_IDLE  = 3'h0,
		B_START = 3'h1,
		B_BYTE  = 3'h2,
		B_ACK   = 3'h3,
		B_STOP  = 3'h4
	} fsc_bus_t;

	typedef enum logic [2:0] {
		S_CFG   = 3'h0,
		S_ALEN  = 3'h1,
		S_SPD   = 3'h2,
		S_STAT  = 3'h3,
		S_SPEED_COUNTER_OVERFLOW_ALARM  = 3'h4,
		S_GAP   = 3'h5
	} fsc_seq_t;

endpackage

// >>> logic/fsc_sync.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps

module fsc_sync #(
	parameter int W = 1  // number of bits
) (
	input  wire logic         clk,  // system clock
	input  wire logic         rst,  // synchronous reset, active high
	input  wire logic [W-1:0] din,  // asynchronous input
	input  wire logic [W-1:0] init, // value held during reset
	output logic      [W-1:0] dout  // synchronised output
);

	logic [W-1:0] s1_q;  // first stage, read only by second stage
	logic [W-1:0] s2_q;  // second stage

	// ==========================================
	// two registers in series
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= init;
			s2_q <= init;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end

	assign dout = s2_q;

endmodule

// >>> logic/fsc_top.sv
// fan speed controller: bus engine and configure/poll sequencer
//
// Overview of operation
// - configure chip fully before speed regulation starts
// - talk to the chip by standard two-wire protocol
// - setup writes speed; poll loop reads back state
// - bus clock from system clock, programmable prescaler
// - switch low selects about 2000 rpm
// - switch high selects about 5000 rpm
// - no alarm latching during settling after change
// - detected alarm lights its matching led
// - alarm leds hold until clear button pressed
// - bits 0,1,2 go to leds 0,1,2
// - bit 3, input-one alarm, goes to led 3
// - status bits 4 to 7 are ignored
`timescale 1ns/1ps

module fsc_i2c (
	input  wire logic        clk,      // system clock
	input  wire logic        rst,      // synchronous reset, active high
	input  wire logic        start,    // begin a register transaction
	input  wire logic        rd,       // 1 read, 0 write
	input  wire logic [7:0]  reg_a,    // register address in the chip
	input  wire logic [7:0]  wdata,    // byte to write
	input  wire logic [15:0] prescale, // system cycles per quarter bit, minus one
	input  wire logic        scl_s,    // synchronised clock line level
	input  wire logic        sda_s,    // synchronised data line level
	output logic             busy,     // transaction in progress
	output logic             done,     // one-cycle pulse at end
	output logic             ack_err,  // chip failed to acknowledge
	output logic [7:0]       rdata,    // byte read
	output logic             scl_oe_n, // low pulls clock line low
	output logic             sda_oe_n  // low pulls data line low
);

	fsc_pkg::fsc_bus_t st_q, st_d;            // bit sequencer state
	logic [1:0]        qt_q, qt_d;            // quarter within a bit
	logic [15:0]       div_q, div_d;          // prescaler count
	logic [2:0]        bit_q, bit_d;          // bit index within byte
	logic [1:0]        step_q, step_d;        // byte index within transaction
	logic [7:0]        sh_q, sh_d;            // shift register
	logic              rd_q, rd_d;            // transaction direction
	logic              err_q, err_d;          // missing acknowledge seen
	logic              done_q, done_d;        // end pulse
	logic [7:0]        rdat_q, rdat_d;        // captured read byte
	logic              scl_q, scl_d;          // clock line drive-low enable, low active
	logic              sda_q, sda_d;          // data line drive-low enable, low active
	logic              scl_hi, sda_hi;        // wanted line levels
	logic              stretch, tick, rbyte;  // helper terms
	logic [7:0]        nbyte;                 // byte for the next step

	// clock held low by the chip while released by us
	assign stretch = scl_q && !scl_s;
	// quarter-bit tick from the prescaler
	assign tick    = (div_q == prescale) && !stretch;
	// data phase of the byte being read
	assign rbyte   = rd_q && (step_q == 2'h3);
	assign busy    = (st_q != fsc_pkg::B_IDLE);
	assign done    = done_q;
	assign ack_err = err_q;
	assign rdata   = rdat_q;
	assign scl_oe_n = scl_q;
	assign sda_oe_n = sda_q;

	// ==========================================
	// byte for each step: address+write, register, data or address+read, read
	always_comb begin
		if (step_d == 2'h0) begin
			nbyte = {fsc_pkg::DEV_ADDR, 1'b0};
		end else if (step_d == 2'h1) begin
			nbyte = reg_a;
		end else if (step_d == 2'h2) begin
			nbyte = rd_q ? {fsc_pkg::DEV_ADDR, 1'b1} : wdata;
		end else begin
			nbyte = 8'hFF;  // released while reading
		end
	end

	// ==========================================
	// line levels per state and quarter: start, data bit, stop
	always_comb begin
		scl_hi = (qt_q == 2'h1) || (qt_q == 2'h2);
		sda_hi = 1'b1;
		case (st_q)
			fsc_pkg::B_IDLE: begin
				scl_hi = 1'b1;
			end
			fsc_pkg::B_START: begin
				sda_hi = (qt_q < 2'h2);  // data falls while clock high
			end
			fsc_pkg::B_BYTE: begin
				sda_hi = rbyte ? 1'b1 : sh_q[7];
			end
			fsc_pkg::B_ACK: begin
				sda_hi = 1'b1;  // release for ack, or nack on read
			end
			fsc_pkg::B_STOP: begin
				scl_hi = (qt_q != 2'h0);
				sda_hi = (qt_q >= 2'h2);  // data rises while clock high
			end
			default: begin
				scl_hi = 1'b1;
			end
		endcase
	end

	// ==========================================
	// next state of the bit sequencer
	always_comb begin
		st_d   = st_q;
		qt_d   = qt_q;
		bit_d  = bit_q;
		step_d = step_q;
		sh_d   = sh_q;
		rd_d   = rd_q;
		err_d  = err_q;
		rdat_d = rdat_q;
		done_d = 1'b0;
		scl_d  = scl_hi;
		sda_d  = sda_hi;
		div_d  = tick ? 16'h0000 : ((div_q == prescale) ? div_q : div_q + 16'h0001);
		if (st_q == fsc_pkg::B_IDLE) begin
			if (start) begin
				st_d   = fsc_pkg::B_START;
				qt_d   = 2'h0;
				step_d = 2'h0;
				rd_d   = rd;
				err_d  = 1'b0;
				div_d  = 16'h0000;
			end
		end else if (tick) begin
			qt_d = qt_q + 2'h1;
			if (st_q == fsc_pkg::B_BYTE && qt_q == 2'h2 && rbyte) begin
				sh_d = {sh_q[6:0], sda_s};  // sample while clock high
			end
			if (st_q == fsc_pkg::B_ACK && qt_q == 2'h2 && !rbyte && sda_s) begin
				err_d = 1'b1;
			end
			if (qt_q == 2'h3) begin
				case (st_q)
					fsc_pkg::B_START: begin
						st_d  = fsc_pkg::B_BYTE;
						bit_d = 3'h7;
						sh_d  = nbyte;
					end
					fsc_pkg::B_BYTE: begin
						if (!rbyte) begin
							sh_d = {sh_q[6:0], 1'b0};
						end
						if (bit_q == 3'h0) begin
							st_d = fsc_pkg::B_ACK;
						end else begin
							bit_d = bit_q - 3'h1;
						end
					end
					fsc_pkg::B_ACK: begin
						if (err_q || (!rd_q && step_q == 2'h2)) begin
							st_d = fsc_pkg::B_STOP;
						end else if (rbyte) begin
							st_d   = fsc_pkg::B_STOP;
							rdat_d = sh_q;
						end else begin
							step_d = step_q + 2'h1;
							bit_d  = 3'h7;
							sh_d   = nbyte;
							// repeated start before the read address
							st_d   = (rd_q && step_q == 2'h1) ? fsc_pkg::B_START : fsc_pkg::B_BYTE;
						end
					end
					default: begin
						st_d   = fsc_pkg::B_IDLE;
						done_d = 1'b1;
					end
				endcase
			end
		end
	end

	// ==========================================
	// bit sequencer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q   <= fsc_pkg::B_IDLE;
			qt_q   <= 2'h0;
			div_q  <= 16'h0000;
			bit_q  <= 3'h7;
			step_q <= 2'h0;
			sh_q   <= 8'hFF;
			rd_q   <= 1'b0;
			err_q  <= 1'b0;
			done_q <= 1'b0;
			rdat_q <= 8'h00;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end else begin
			st_q   <= st_d;
			qt_q   <= qt_d;
			div_q  <= div_d;
			bit_q  <= bit_d;
			step_q <= step_d;
			sh_q   <= sh_d;
			rd_q   <= rd_d;
			err_q  <= err_d;
			done_q <= done_d;
			rdat_q <= rdat_d;
			scl_q  <= scl_d;
			sda_q  <= sda_d;
		end
	end

endmodule

module fsc_top #(
	parameter logic [31:0] SETTLE_CYC = fsc_pkg::SETTLE_CYCLES, // settling window in cycles
	parameter logic [31:0] POLL_CYC   = fsc_pkg::POLL_CYCLES    // gap between polls in cycles
) (
	input  wire logic        CLK_SYS,     // system clock, 100 MHz
	input  wire logic        RST,         // synchronous reset, active high
	input  wire logic        SPEED_SEL,   // speed switch, 0 slow, 1 fast
	input  wire logic        ALARM_CLR_N, // alarm clear button, low when pressed
	input  wire logic [15:0] PRESCALE,    // bus prescaler, quarter bit length minus one
	input  wire logic        SCL_IN,      // clock line level
	output logic             SCL_OUT,     // clock line drive value, always 0
	output logic             SCL_OE_N,    // low pulls clock line low
	input  wire logic        SDA_IN,      // data line level
	output logic             SDA_OUT,     // data line drive value, always 0
	output logic             SDA_OE_N,    // low pulls data line low
	output logic [3:0]       LED,         // latched alarm leds
	output logic             CONFIG_DONE, // chip configured and speed set
	output logic             SETTLING,    // settling window running
	output logic [7:0]       SPEED_COUNTER_OVERFLOW_ALARM_COUNT,  // last tachometer reading
	output logic             BUS_ERROR    // last transaction unacknowledged
);

	logic [3:0]        syn;                 // synchronised pins
	logic              busy, done, aerr;    // engine status
	logic [7:0]        rdata;               // engine read byte
	logic              start, c_rd;         // engine command
	logic [7:0]        c_reg, c_dat;        // engine command fields
	fsc_pkg::fsc_seq_t st_q, st_d;          // sequencer state
	logic              iss_q, iss_d;        // command issued, awaiting done
	logic              sel_q, sel_d;        // speed setting last written
	logic [31:0]       set_q, set_d;        // settling countdown
	logic [31:0]       gap_q, gap_d;        // poll gap countdown
	logic [3:0]        led_q, led_d;        // alarm leds
	logic [7:0]        speed_counter_overflow_alarm_q, speed_counter_overflow_alarm_d;      // tachometer reading
	logic              cfg_q, cfg_d;        // configuration complete
	logic              err_q, err_d;        // last error

	// ==========================================
	// pin synchronisers: speed, clear, clock line, data line
	fsc_sync #(.W(4)) u_sync (
		.clk  (CLK_SYS),
		.rst  (RST),
		.din  ({SPEED_SEL, ALARM_CLR_N, SCL_IN, SDA_IN}),
		.init (4'h7),
		.dout (syn)
	);

	// ==========================================
	// bus engine
	fsc_i2c u_bus (
		.clk      (CLK_SYS),
		.rst      (RST),
		.start    (start),
		.rd       (c_rd),
		.reg_a    (c_reg),
		.wdata    (c_dat),
		.prescale (PRESCALE),
		.scl_s    (syn[1]),
		.sda_s    (syn[0]),
		.busy     (busy),
		.done     (done),
		.ack_err  (aerr),
		.rdata    (rdata),
		.scl_oe_n (SCL_OE_N),
		.sda_oe_n (SDA_OE_N)
	);

	assign SCL_OUT     = 1'b0;
	assign SDA_OUT     = 1'b0;
	assign LED         = led_q;
	assign CONFIG_DONE = cfg_q;
	assign SETTLING    = (set_q != 32'h0000_0000);
	assign SPEED_COUNTER_OVERFLOW_ALARM_COUNT  = speed_counter_overflow_alarm_q;
	assign BUS_ERROR   = err_q;
	// one command at a time, none in the poll gap, while the engine is free
	assign start = !iss_q && !busy && (st_q != fsc_pkg::S_GAP);

	// ==========================================
	// command for the current state
	always_comb begin
		c_rd  = 1'b0;
		c_dat = 8'h00;
		c_reg = fsc_pkg::REG_ALARM_STAT;
		case (st_q)
			fsc_pkg::S_CFG: begin
				c_reg = fsc_pkg::REG_CONFIG;
				c_dat = fsc_pkg::CONFIG_VAL;
			end
			fsc_pkg::S_ALEN: begin
				c_reg = fsc_pkg::REG_ALARM_EN;
				c_dat = fsc_pkg::ALARM_EN_VAL;
			end
			fsc_pkg::S_SPD: begin
				c_reg = fsc_pkg::REG_SPEED;
				c_dat = syn[3] ? fsc_pkg::SPEED_5000 : fsc_pkg::SPEED_2000;
			end
			fsc_pkg::S_SPEED_COUNTER_OVERFLOW_ALARM: begin
				c_rd  = 1'b1;
				c_reg = fsc_pkg::REG_SPEED_COUNTER_OVERFLOW_ALARM;
			end
			default: begin
				c_rd  = 1'b1;  // status poll
			end
		endcase
	end

	// ==========================================
	// sequencer: configure, set speed, then poll forever
	always_comb begin
		st_d   = st_q;
		iss_d  = iss_q;
		sel_d  = sel_q;
		cfg_d  = cfg_q;
		err_d  = err_q;
		speed_counter_overflow_alarm_d = speed_counter_overflow_alarm_q;
		gap_d  = gap_q;
		set_d  = (set_q != 32'h0000_0000) ? set_q - 32'h0000_0001 : set_q;
		led_d  = syn[2] ? led_q : fsc_pkg::LED_RESET;
		if (start) begin
			iss_d = 1'b1;
			if (st_q == fsc_pkg::S_SPD) begin
				sel_d = syn[3];
			end
		end
		if (done) begin
			iss_d = 1'b0;
			err_d = aerr;
			// an unacknowledged command repeats in the same state
			if (!aerr) begin
				case (st_q)
					fsc_pkg::S_CFG: begin
						st_d = fsc_pkg::S_ALEN;
					end
					fsc_pkg::S_ALEN: begin
						st_d = fsc_pkg::S_SPD;
					end
					fsc_pkg::S_SPD: begin
						st_d  = fsc_pkg::S_STAT;
						cfg_d = 1'b1;
						set_d = SETTLE_CYC;
					end
					fsc_pkg::S_STAT: begin
						st_d = fsc_pkg::S_SPEED_COUNTER_OVERFLOW_ALARM;
						if (set_q == 32'h0000_0000) begin
							// set wins over a clear in the same cycle; bits 4-7 dropped
							led_d[fsc_pkg::ALM_MAX_POS]  = led_d[fsc_pkg::ALM_MAX_POS]
								| rdata[fsc_pkg::ALM_MAX_POS];
							led_d[fsc_pkg::ALM_MIN_POS]  = led_d[fsc_pkg::ALM_MIN_POS]
								| rdata[fsc_pkg::ALM_MIN_POS];
							led_d[fsc_pkg::ALM_OVF_POS]  = led_d[fsc_pkg::ALM_OVF_POS]
								| rdata[fsc_pkg::ALM_OVF_POS];
							led_d[fsc_pkg::ALM_GIN1_POS] = led_d[fsc_pkg::ALM_GIN1_POS]
								| rdata[fsc_pkg::ALM_GIN1_POS];
						end
					end
					fsc_pkg::S_SPEED_COUNTER_OVERFLOW_ALARM: begin
						st_d   = fsc_pkg::S_GAP;
						speed_counter_overflow_alarm_d = rdata;
						gap_d  = POLL_CYC;
					end
					default: begin
						st_d = fsc_pkg::S_STAT;
					end
				endcase
			end
		end
		if (st_q == fsc_pkg::S_GAP) begin
			if (gap_q == 32'h0000_0000) begin
				// a moved switch rewrites the speed, else poll again
				st_d = (syn[3] != sel_q) ? fsc_pkg::S_SPD : fsc_pkg::S_STAT;
			end else begin
				gap_d = gap_q - 32'h0000_0001;
			end
		end
	end

	// ==========================================
	// sequencer registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_q   <= fsc_pkg::S_CFG;
			iss_q  <= 1'b0;
			sel_q  <= 1'b0;
			set_q  <= 32'h0000_0000;
			gap_q  <= 32'h0000_0000;
			led_q  <= fsc_pkg::LED_RESET;
			speed_counter_overflow_alarm_q <= 8'h00;
			cfg_q  <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			iss_q  <= iss_d;
			sel_q  <= sel_d;
			set_q  <= set_d;
			gap_q  <= gap_d;
			led_q  <= led_d;
			speed_counter_overflow_alarm_q <= speed_counter_overflow_alarm_d;
			cfg_q  <= cfg_d;
			err_q  <= err_d;
		end
	end

endmodule

// >>> testbench/fsc_chip_model.sv
// behavioural model of the fan controller chip on the two-wire bus
`timescale 1ns/1ps
module fsc_chip_model (
	input  wire logic       scl,     // clock line level
	input  wire logic       sda,     // data line level
	input  wire logic       nack,    // refuse every byte when high
	input  wire logic [7:0] status,  // alarm status to report
	input  wire logic [7:0] speed_counter_overflow_alarm,    // speed_counter_overflow_alarm count to report
	output logic            sda_pull // high pulls data line low
);
	logic [7:0] regs [0:15]; // register file by low pointer nibble
	logic [7:0] sh;          // incoming byte
	logic [7:0] ptr;         // register pointer
	logic [7:0] out;         // outgoing byte
	logic       rd;          // read direction
	int         bitn;        // clock pulses in current byte
	int         byten;       // bytes since start

	initial begin
		sda_pull = 1'b0;
		bitn = 0;
		byten = 0;
		rd = 1'b0;
		ptr = 8'h00;
		for (int i = 0; i < 16; i++) regs[i] = 8'h00;
	end
	// start or repeated start restarts framing
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			bitn = 0;
			byten = 0;
		end
	end
	// sample data on rising clock, msb first
	always @(posedge scl) begin
		if (bitn < 8) sh = {sh[6:0], sda};
		bitn = bitn + 1;
	end
	// acknowledge and shift out on falling clock
	always @(negedge scl) begin
		if (bitn == 8) begin
			if (byten == 0) rd = sh[0];
			if (byten == 1 && !rd) ptr = sh;
			if (byten > 1 && !rd) regs[ptr[3:0]] = sh;
			sda_pull = !nack && (byten > 0 ? !rd : sh[7:1] == 7'h1B);
			byten = byten + 1;
		end else if (bitn == 9) begin
			bitn = 0;
			out = ptr == 8'h0A ? status : (ptr == 8'h0C ? speed_counter_overflow_alarm : regs[ptr[3:0]]);
			sda_pull = rd && byten == 1 && !out[7];
		end else if (rd && byten == 1 && bitn > 0) begin
			sda_pull = !out[7 - bitn];
		end
	end
endmodule

// >>> testbench/fsc_top_asserts.sv
// concurrent checks on the fan speed controller top ports
`timescale 1ns/1ps
module fsc_top_asserts #(
	parameter logic [31:0] SETTLE_CYC = 32'h0, // settling window in cycles
	parameter logic [31:0] POLL_CYC   = 32'h0  // poll gap in cycles
) (
	input wire logic       CLK_SYS,     // system clock
	input wire logic       RST,         // synchronous reset
	input wire logic       ALARM_CLR_N, // clear button, low pressed
	input wire logic       SCL_OUT,     // clock line drive value
	input wire logic       SCL_OE_N,    // low pulls clock line
	input wire logic       SDA_OUT,     // data line drive value
	input wire logic       SDA_OE_N,    // low pulls data line
	input wire logic [3:0] LED,         // latched alarms
	input wire logic       CONFIG_DONE, // chip configured
	input wire logic       SETTLING,    // settling window running
	input wire logic [7:0] SPEED_COUNTER_OVERFLOW_ALARM_COUNT   // last speed_counter_overflow_alarm byte
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// ==========================================
	// helper: length of the current settling run
	logic [31:0] run_q; // cycles settling has been high
	logic [31:0] run_d; // next run length
	always_comb begin
		run_d = (RST || !SETTLING) ? 32'h0 : run_q + 32'h1;
	end
	always_ff @(posedge CLK_SYS) begin
		run_q <= run_d;
	end

	// ==========================================
	// sequences and properties
	sequence s_start; SCL_OE_N && $past(SCL_OE_N) && $fell(SDA_OE_N); endsequence
	sequence s_clock_low; ##[1:16] !SCL_OE_N; endsequence
	property p_start_then_clock; s_start |-> s_clock_low; endproperty
	property p_drive_low; SCL_OUT == 1'b0 && SDA_OUT == 1'b0; endproperty
	property p_reset_state;
		@(posedge CLK_SYS) disable iff (1'b0)
		RST |=> (SCL_OE_N && SDA_OE_N && LED == 4'h0 && !CONFIG_DONE && !SETTLING);
	endproperty
	property p_config_sticky; CONFIG_DONE |=> CONFIG_DONE; endproperty
	property p_quiet_before_config; !CONFIG_DONE |-> (LED == 4'h0 && SPEED_COUNTER_OVERFLOW_ALARM_COUNT == 8'h00); endproperty
	property p_led_hold;
		(|($past(LED) & ~LED)) |->
		!($past(ALARM_CLR_N, 2) && $past(ALARM_CLR_N, 3) && $past(ALARM_CLR_N, 4) && $past(ALARM_CLR_N, 5));
	endproperty
	property p_settle_mask;
		($past(SETTLING, 1) && $past(SETTLING, 2) && $past(SETTLING, 3)) |-> (LED & ~$past(LED)) == 4'h0;
	endproperty
	property p_settle_len; SETTLING |-> run_q <= SETTLE_CYC; endproperty

	// ==========================================
	// assertions
	a_start_then_clock: assert property (p_start_then_clock) else $error("start without clock low");
	a_drive_low: assert property (p_drive_low) else $error("line drive value not zero");
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
	a_config_sticky: assert property (p_config_sticky) else $error("config done dropped");
	a_quiet_before_config: assert property (p_quiet_before_config) else $error("activity before config");
	a_led_hold: assert property (p_led_hold) else $error("led cleared without button");
	a_settle_mask: assert property (p_settle_mask) else $error("alarm latched while settling");
	a_settle_len: assert property (p_settle_len) else $error("settling too long");
endmodule

bind fsc_top fsc_top_asserts #(.SETTLE_CYC(SETTLE_CYC), .POLL_CYC(POLL_CYC)) u_asserts (
	.CLK_SYS(CLK_SYS), .RST(RST), .ALARM_CLR_N(ALARM_CLR_N), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
	.SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .LED(LED), .CONFIG_DONE(CONFIG_DONE), .SETTLING(SETTLING),
	.SPEED_COUNTER_OVERFLOW_ALARM_COUNT(SPEED_COUNTER_OVERFLOW_ALARM_COUNT));

// >>> testbench/testbench.sv
// self-checking testbench for the fan speed controller
`timescale 1ns/1ps
module testbench;
	// ==========================================
	// signals
	logic       clk_sys     = 1'b0;  // system clock
	logic       rst         = 1'b1;  // reset
	logic       speed_sel   = 1'b0;  // speed switch
	logic       alarm_clr_n = 1'b1;  // clear button
	logic       nack        = 1'b0;  // chip refuses bytes
	logic [7:0] status      = 8'h00; // chip alarm status
	logic [7:0] speed_counter_overflow_alarm        = 8'h00; // chip speed_counter_overflow_alarm count
	logic       scl_oe_n;            // block pulls clock
	logic       sda_oe_n;            // block pulls data
	logic       sda_pull;            // chip pulls data
	logic       config_done;         // configured flag
	logic       settling;            // settling flag
	logic       bus_error;           // last transfer refused
	logic [3:0] led;                 // alarm leds
	logic [7:0] speed_counter_overflow_alarm_count;          // speed_counter_overflow_alarm reading
	logic [3:0] exp_led;             // expected leds
	logic [15:0] prescale   = 16'h0001; // bus prescaler, quarter bit minus one
	int         bit_cycles;          // measured length of one bus bit
	wire        scl = scl_oe_n;      // pulled up, only the block drives it
	wire        sda = sda_oe_n & ~sda_pull; // pulled up, wired and
	int         fails = 0;           // mismatches
	int         check_count = 0;     // comparisons

	always #5 clk_sys = ~clk_sys;

	fsc_top #(.SETTLE_CYC(32'h7D0), .POLL_CYC(32'h32)) u_dut (
		.CLK_SYS(clk_sys), .RST(rst), .SPEED_SEL(speed_sel), .ALARM_CLR_N(alarm_clr_n), .PRESCALE(prescale),
		.SCL_IN(scl), .SCL_OUT(), .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(sda_oe_n),
		.LED(led), .CONFIG_DONE(config_done), .SETTLING(settling), .SPEED_COUNTER_OVERFLOW_ALARM_COUNT(speed_counter_overflow_alarm_count),
		.BUS_ERROR(bus_error));
	fsc_chip_model u_chip (.scl(scl), .sda(sda), .nack(nack), .status(status), .speed_counter_overflow_alarm(speed_counter_overflow_alarm),
		.sda_pull(sda_pull));

	// ==========================================
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// set the switch, the chip answers and the refusal
	task automatic set_env(input logic sel, input logic [7:0] st, input logic [7:0] tc, input logic nk);
		@(posedge clk_sys);
		speed_sel <= sel;
		status <= st;
		speed_counter_overflow_alarm <= tc;
		nack <= nk;
	endtask
	// wait cycles, then let outputs settle
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// hold the clear button for a few cycles
	task automatic press_clear();
		@(posedge clk_sys);
		alarm_clr_n <= 1'b0;
		idle(8);
		@(posedge clk_sys);
		alarm_clr_n <= 1'b1;
		idle(8);
	endtask
	// cycles between the first two clock pulses after a start, one full bit
	task automatic bit_time(output int n);
		time t0;
		@(negedge sda iff (scl === 1'b1));
		@(posedge scl);
		t0 = $time;
		@(posedge scl);
		n = int'(($time - t0) / 10);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ==========================================
	// watchdog
	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		stop_test();
	end

	// ==========================================
	// main sequence
	initial begin
		idle(19);
		check({3'h0, bus_error, led}, 8'h00, "reset outputs");
		@(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5000 && config_done !== 1'b1; i++) idle(1);
		check({7'h0, config_done}, 8'h01, "config done");
		check(u_chip.regs[fsc_pkg::REG_CONFIG[3:0]], fsc_pkg::CONFIG_VAL, "config word");
		check(u_chip.regs[fsc_pkg::REG_ALARM_EN[3:0]], fsc_pkg::ALARM_EN_VAL, "alarm enable");
		check(u_chip.regs[fsc_pkg::REG_SPEED[3:0]], fsc_pkg::SPEED_2000, "slow speed");
		$display("test config done");
		set_env(1'b0, 8'h00, 8'hA5, 1'b0);
		for (int i = 0; i < 3000 && speed_counter_overflow_alarm_count !== 8'hA5; i++) idle(1);
		check(speed_counter_overflow_alarm_count, 8'hA5, "speed_counter_overflow_alarm readback");
		$display("test speed_counter_overflow_alarm done");
		for (int i = 0; i < 5000 && settling !== 1'b0; i++) idle(1);
		check({7'h0, settling}, 8'h00, "settling ends");
		exp_led = 4'h0;
		for (int b = 0; b < 4; b++) begin
			set_env(1'b0, 8'hF0 | (8'h01 << b), 8'hA5, 1'b0);
			exp_led = exp_led | (4'h1 << b);
			for (int i = 0; i < 3000 && led !== exp_led; i++) idle(1);
			check({4'h0, led}, {4'h0, exp_led}, "alarm bit to led");
		end
		set_env(1'b0, 8'h00, 8'hA5, 1'b0);
		idle(1500);
		check({4'h0, led}, 8'h0F, "alarms held");
		press_clear();
		check({4'h0, led}, 8'h00, "alarms cleared");
		$display("test alarms done");
		set_env(1'b1, 8'h00, 8'hA5, 1'b0);
		for (int i = 0; i < 3000 && settling !== 1'b1; i++) idle(1);
		check({7'h0, settling}, 8'h01, "settling after change");
		check(u_chip.regs[fsc_pkg::REG_SPEED[3:0]], fsc_pkg::SPEED_5000, "fast speed");
		set_env(1'b1, 8'h01, 8'hA5, 1'b0);
		idle(1500);
		check({4'h0, led}, 8'h00, "no alarm while settling");
		for (int i = 0; i < 3000 && led !== 4'h1; i++) idle(1);
		check({4'h0, led}, 8'h01, "alarm after settling");
		$display("test speed change done");
		// new speed_counter_overflow_alarm value marks the start of the poll gap, so the next status read is refused
		set_env(1'b1, 8'h02, 8'h5A, 1'b0);
		for (int i = 0; i < 3000 && speed_counter_overflow_alarm_count !== 8'h5A; i++) idle(1);
		check(speed_counter_overflow_alarm_count, 8'h5A, "speed_counter_overflow_alarm update");
		set_env(1'b1, 8'h02, 8'h5A, 1'b1);
		press_clear();
		for (int i = 0; i < 3000 && bus_error !== 1'b1; i++) idle(1);
		check({7'h0, bus_error}, 8'h01, "refused transfer");
		idle(1000);
		check({4'h0, led}, 8'h00, "refused read ignored");
		// recover with a slower bus: prescaler only grows, never below its count
		set_env(1'b1, 8'h02, 8'h5A, 1'b0);
		prescale <= 16'h0003;
		for (int i = 0; i < 3000 && led !== 4'h2; i++) idle(1);
		check({3'h0, bus_error, led}, 8'h02, "recovery after refusal");
		bit_time(bit_cycles);
		check(bit_cycles[7:0], 8'h10, "bit time from prescaler");
		$display("test refusal done");
		stop_test();
	end
endmodule
